//--- common/timer_cfg.svh
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
// Behaviour
// - Tick from internal prescaler or external pin
// - No clock selected: counter holds its value
// - Count value zero flags BOTTOM
// - Count value all ones flags MAX
// - TOP is fixed value or capture register
// - 16-bit registers reached as two bytes
// - One shared temporary high-byte register
// - Low-byte write loads temp and low together (capture only while it is TOP)
// - Low-byte read copies high byte to temp
// - One temp write serves several low writes
// - Control registers take single byte accesses
// - Overflow and capture flags in flag register
// - Each request gated by its mask bit
// - Capture edge copies counter to capture register unless capture register is TOP
// - Noise canceler filters capture input spikes
// - Select 7 rising, 6 falling external edges
// - Capture flag sets with the capture copy
// - Counter write beats clear and count

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ADDR_W 6
`define OFF_CNT_LO 6'h00
`define OFF_CNT_HI 6'h04
`define OFF_CAP_LO 6'h08
`define OFF_CAP_HI 6'h0C
`define OFF_CTRL_A 6'h10
`define OFF_CTRL_B 6'h14
`define OFF_FLAG 6'h18
`define OFF_MASK 6'h1C
`define OFF_POWER 6'h20

// ----------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------
`define CS_LO 0
`define CS_HI 2
`define TOP_CAP_BIT 4
`define CAP_RISE_BIT 6
`define NC_EN_BIT 7
`define TOP_SEL_LO 0
`define TOP_SEL_HI 1
`define OVF_BIT 0
`define CAP_BIT 1
`define PWR_BIT 0
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define TOP_SEL_MAX 2'h0
`define TOP_SEL_8 2'h1
`define TOP_SEL_9 2'h2
`define TOP_SEL_10 2'h3
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hFFFF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PRE_W 10
`define PRE_MASK1 10'h000
`define PRE_MASK8 10'h007
`define PRE_MASK64 10'h03F
`define PRE_MASK256 10'h0FF
`define PRE_MASK1024 10'h3FF
`define NC_DEPTH 4
`endif

//--- common/timer_pkg.sv
`include "timer_cfg.svh"
package timer_pkg;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [7:0] byte_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] capture;
		byte_t temp;
		byte_t ctrl_a;
		byte_t ctrl_b;
		logic ovf_flag;
		logic cap_flag;
		logic ovf_mask;
		logic cap_mask;
		logic pwr_off;
		logic [`PRE_W-1:0] presc;
		logic aw_have;
		addr_t aw_addr;
		logic w_have;
		byte_t w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		byte_t rdata;
		logic [1:0] rresp;
		logic at_bottom;
		logic at_max;
		logic at_top;
		logic tick;
	} core_state_t;

	typedef struct packed {
		logic cap_s;
		logic [`NC_DEPTH-1:0] hist;
		logic cap_lvl;
		logic ext_s;
		logic ext_prev;
		logic cap_ev;
		logic ext_tick;
	} cond_state_t;
endpackage: timer_pkg

//--- common/cond_if.sv
`timescale 1ns/1ns
interface cond_if;
	logic cap_pin;
	logic ext_pin;
	logic cap_rise;
	logic nc_en;
	logic [2:0] cs;
	logic cap_ev;
	logic ext_tick;

	modport core (
		output cap_pin, ext_pin, cap_rise, nc_en, cs,
		input cap_ev, ext_tick
	);
	modport cond (
		input cap_pin, ext_pin, cap_rise, nc_en, cs,
		output cap_ev, ext_tick
	);
endinterface: cond_if

//--- logic/pin_conditioner.sv
`timescale 1ns/1ns
`include "timer_cfg.svh"

module pin_conditioner (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Pin events
	cond_if.cond io
);
	import timer_pkg::*;

	cond_state_t q;
	cond_state_t d;

	// ------------------------------------------------------------------
	// Filter and edge detection
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		d.cap_s = io.cap_pin;
		d.hist = {q.hist[`NC_DEPTH-2:0], q.cap_s};
		if (io.nc_en) begin
			if (&d.hist)
				d.cap_lvl = 1'b1;
			else if (~|d.hist)
				d.cap_lvl = 1'b0;
		end else begin
			d.cap_lvl = q.cap_s;
		end
		if (io.cap_rise)
			d.cap_ev = d.cap_lvl & ~q.cap_lvl;
		else
			d.cap_ev = ~d.cap_lvl & q.cap_lvl;
		d.ext_s = io.ext_pin;
		d.ext_prev = q.ext_s;
		if (io.cs == `CS_EXT_RISE)
			d.ext_tick = q.ext_s & ~q.ext_prev;
		else if (io.cs == `CS_EXT_FALL)
			d.ext_tick = ~q.ext_s & q.ext_prev;
		else
			d.ext_tick = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign io.cap_ev = q.cap_ev;
	assign io.ext_tick = q.ext_tick;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	ext_rise_a: assert property (
		ce && io.cs == `CS_EXT_RISE && q.ext_s && !q.ext_prev
		|=> io.ext_tick)
		else $error("rising external edge gave no tick");

	nc_filter_a: assert property (
		ce && io.nc_en && d.cap_lvl != q.cap_lvl
		|-> (&d.hist || ~|d.hist))
		else $error("capture level moved on a spike");

	ext_tick_c: cover property (io.ext_tick);
endmodule: pin_conditioner

//--- logic/timer16_core.sv
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "timer_cfg.svh"

module timer16_core (
	// Clock, reset and enable
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic CLK_EN,
	// Write address channel
	input wire timer_pkg::addr_t S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// Write data channel
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// Write response channel
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// Read address channel
	input wire timer_pkg::addr_t S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// Read data channel
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Timer pins
	input wire logic CAPTURE_INPUT_PIN,
	input wire logic EXT_COUNT_CLOCK_PIN,
	// Counter status
	output logic TIMER_TICK,
	output logic COUNT_AT_BOTTOM,
	output logic COUNT_AT_MAX,
	output logic COUNT_AT_TOP,
	// Interrupt requests
	output logic IRQ_OVERFLOW,
	output logic IRQ_CAPTURE
);
	import timer_pkg::*;

	core_state_t q;
	core_state_t d;
	logic [2:0] cs;
	logic run;
	logic tick;
	logic topcap;
	logic wr_go;
	logic rd_go;
	logic wr_ok;
	logic rd_ok;
	logic cnt_lo_wr;
	logic temp_wr;
	logic cap_go;
	logic ovf_set;
	logic ovf_clr;
	logic cap_clr;
	logic [15:0] top;
	logic [`PRE_W-1:0] pmask;
	byte_t rd_val;

	cond_if io ();

	pin_conditioner u_cond (
		.clk(REF_CLK),
		.rst(RESET),
		.ce(CLK_EN),
		.io(io)
	);

	// ------------------------------------------------------------------
	// Pin conditioner configuration
	// ------------------------------------------------------------------
	assign io.cap_pin = CAPTURE_INPUT_PIN;
	assign io.ext_pin = EXT_COUNT_CLOCK_PIN;
	assign io.cap_rise = q.ctrl_b[`CAP_RISE_BIT];
	assign io.nc_en = q.ctrl_b[`NC_EN_BIT];
	assign io.cs = q.ctrl_b[`CS_HI:`CS_LO];

	// ------------------------------------------------------------------
	// Bus handshakes
	// ------------------------------------------------------------------
	assign S_AXI_AWREADY = CLK_EN & ~q.aw_have & ~q.bvalid;
	assign S_AXI_WREADY = CLK_EN & ~q.w_have & ~q.bvalid;
	assign S_AXI_ARREADY = CLK_EN & ~q.rvalid;
	assign S_AXI_BVALID = q.bvalid;
	assign S_AXI_BRESP = q.bresp;
	assign S_AXI_RVALID = q.rvalid;
	assign S_AXI_RRESP = q.rresp;
	assign S_AXI_RDATA = {24'h000000, q.rdata};

	// ------------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------------
	assign TIMER_TICK = q.tick;
	assign COUNT_AT_BOTTOM = q.at_bottom;
	assign COUNT_AT_MAX = q.at_max;
	assign COUNT_AT_TOP = q.at_top;
	assign IRQ_OVERFLOW = q.ovf_flag & q.ovf_mask;
	assign IRQ_CAPTURE = q.cap_flag & q.cap_mask;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		cs = q.ctrl_b[`CS_HI:`CS_LO];
		topcap = q.ctrl_b[`TOP_CAP_BIT];
		run = ~q.pwr_off;
		wr_go = q.aw_have & q.w_have & ~q.bvalid;
		rd_go = S_AXI_ARVALID & ~q.rvalid;
		cnt_lo_wr = wr_go & q.w_strb0 & (q.aw_addr == `OFF_CNT_LO);
		temp_wr = wr_go & q.w_strb0
			& ((q.aw_addr == `OFF_CNT_HI) | (q.aw_addr == `OFF_CAP_HI));
		cap_go = io.cap_ev & run & ~topcap;
		ovf_set = 1'b0;
		ovf_clr = 1'b0;
		cap_clr = 1'b0;
		wr_ok = 1'b1;

		if (topcap) begin
			top = q.capture;
		end else begin
			unique case (q.ctrl_a[`TOP_SEL_HI:`TOP_SEL_LO])
				`TOP_SEL_MAX: top = `CNT_MAX;
				`TOP_SEL_8: top = `TOP_8;
				`TOP_SEL_9: top = `TOP_9;
				`TOP_SEL_10: top = `TOP_10;
			endcase
		end

		unique case (cs)
			`CS_DIV8: pmask = `PRE_MASK8;
			`CS_DIV64: pmask = `PRE_MASK64;
			`CS_DIV256: pmask = `PRE_MASK256;
			`CS_DIV1024: pmask = `PRE_MASK1024;
			default: pmask = `PRE_MASK1;
		endcase

		if (run && cs >= `CS_DIV1 && cs <= `CS_DIV1024) begin
			tick = (q.presc & pmask) == pmask;
			d.presc = q.presc + 1'b1;
		end else begin
			tick = run & (cs == `CS_EXT_FALL || cs == `CS_EXT_RISE)
				& io.ext_tick;
			d.presc = '0;
		end
		d.tick = tick;

		if (tick) begin
			if (q.count == top || q.count == `CNT_MAX) begin
				d.count = `CNT_BOTTOM;
				ovf_set = 1'b1;
			end else begin
				d.count = q.count + 16'h0001;
			end
		end

		if (cap_go)
			d.capture = q.count;

		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			d.aw_have = 1'b1;
			d.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			d.w_have = 1'b1;
			d.w_data = S_AXI_WDATA[7:0];
			d.w_strb0 = S_AXI_WSTRB[0];
		end
		if (q.bvalid && S_AXI_BREADY)
			d.bvalid = 1'b0;
		if (q.rvalid && S_AXI_RREADY)
			d.rvalid = 1'b0;

		rd_val = '0;
		rd_ok = 1'b1;
		unique case (S_AXI_ARADDR)
			`OFF_CNT_LO: rd_val = q.count[7:0];
			`OFF_CNT_HI: rd_val = q.temp;
			`OFF_CAP_LO: rd_val = q.capture[7:0];
			`OFF_CAP_HI: rd_val = q.temp;
			`OFF_CTRL_A: rd_val = q.ctrl_a;
			`OFF_CTRL_B: rd_val = q.ctrl_b;
			`OFF_FLAG: begin
				rd_val[`OVF_BIT] = q.ovf_flag;
				rd_val[`CAP_BIT] = q.cap_flag;
			end
			`OFF_MASK: begin
				rd_val[`OVF_BIT] = q.ovf_mask;
				rd_val[`CAP_BIT] = q.cap_mask;
			end
			`OFF_POWER: rd_val[`PWR_BIT] = q.pwr_off;
			default: rd_ok = 1'b0;
		endcase
		if (rd_go) begin
			d.rvalid = 1'b1;
			d.rdata = rd_val;
			d.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			if (S_AXI_ARADDR == `OFF_CNT_LO)
				d.temp = q.count[15:8];
			else if (S_AXI_ARADDR == `OFF_CAP_LO)
				d.temp = q.capture[15:8];
		end

		if (wr_go) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			unique case (q.aw_addr)
				`OFF_CNT_LO: if (q.w_strb0) begin
					d.count = {q.temp, q.w_data};
				end
				`OFF_CNT_HI, `OFF_CAP_HI: if (q.w_strb0) begin
					d.temp = q.w_data;
				end
				`OFF_CAP_LO: if (q.w_strb0 && topcap) begin
					d.capture = {q.temp, q.w_data};
				end
				`OFF_CTRL_A: if (q.w_strb0) begin
					d.ctrl_a = q.w_data;
				end
				`OFF_CTRL_B: if (q.w_strb0) begin
					d.ctrl_b = q.w_data;
				end
				`OFF_FLAG: if (q.w_strb0) begin
					ovf_clr = q.w_data[`OVF_BIT];
					cap_clr = q.w_data[`CAP_BIT];
				end
				`OFF_MASK: if (q.w_strb0) begin
					d.ovf_mask = q.w_data[`OVF_BIT];
					d.cap_mask = q.w_data[`CAP_BIT];
				end
				`OFF_POWER: if (q.w_strb0) begin
					d.pwr_off = q.w_data[`PWR_BIT];
				end
				default: wr_ok = 1'b0;
			endcase
			d.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end

		d.ovf_flag = (q.ovf_flag & ~ovf_clr) | ovf_set;
		d.cap_flag = (q.cap_flag & ~cap_clr) | cap_go;

		d.at_bottom = d.count == `CNT_BOTTOM;
		d.at_max = d.count == `CNT_MAX;
		d.at_top = d.count == top;
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			q <= '0;
			q.pwr_off <= 1'b1;
			q.at_bottom <= 1'b1;
		end else if (CLK_EN) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	stop_hold_a: assert property (
		CLK_EN && cs == `CS_STOP && !cnt_lo_wr |=> $stable(q.count))
		else $error("counter moved with no clock selected");

	power_idle_a: assert property (
		CLK_EN && q.pwr_off && !cnt_lo_wr && !(wr_go && topcap)
		|=> $stable(q.count) && $stable(q.capture))
		else $error("timer active while powered off");

	low_write_a: assert property (
		CLK_EN && cnt_lo_wr
		|=> q.count == {$past(q.temp), $past(q.w_data)})
		else $error("counter write did not load temp and low");

	read_copy_a: assert property (
		CLK_EN && rd_go && S_AXI_ARADDR == `OFF_CNT_LO && !temp_wr
		|=> q.temp == $past(q.count[15:8]) ##0 S_AXI_RVALID)
		else $error("low read did not copy high byte");

	capture_copy_a: assert property (
		CLK_EN && cap_go |=> q.capture == $past(q.count) ##0 q.cap_flag)
		else $error("capture copy or flag missing");

	top_wrap_a: assert property (
		CLK_EN && tick && q.count == top && !cnt_lo_wr
		|=> q.count == `CNT_BOTTOM && q.ovf_flag && q.at_bottom)
		else $error("counter did not wrap at top");

	irq_gate_a: assert property (
		CLK_EN && ovf_set && q.ovf_mask && !(wr_go && q.aw_addr == `OFF_MASK)
		|=> IRQ_OVERFLOW)
		else $error("unmasked overflow raised no request");

	flag_hold_a: assert property (
		CLK_EN && cap_go && cap_clr |=> q.cap_flag)
		else $error("capture event lost to flag clear");

	bus_resp_a: assert property (
		CLK_EN && S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped early");

	freeze_hold_a: assert property (
		!CLK_EN |=> $stable(q))
		else $error("state moved while clock enable was low");

	bottom_flag_a: assert property (
		CLK_EN |=> COUNT_AT_BOTTOM == (q.count == `CNT_BOTTOM))
		else $error("bottom status disagrees with counter");

	capture_c: cover property (cap_go);
	overflow_c: cover property (ovf_set && topcap);
	cnt_write_c: cover property (cnt_lo_wr && tick);
	read_c: cover property (rd_go ##1 S_AXI_RVALID && S_AXI_RREADY);
endmodule: timer16_core

//--- tb/pin_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Pin source model
// ----------------------------------------------------------------------
module pin_model (
	// Clock
	input wire logic clk,
	// Pins
	output logic cap_pin,
	output logic ext_pin
);
	initial begin
		cap_pin = 1'h0;
		ext_pin = 1'h0;
	end
	task pulse(input int n);
		repeat (n) begin
			ext_pin <= 1'h1;
			repeat (3) @(posedge clk);
			ext_pin <= 1'h0;
			repeat (3) @(posedge clk);
		end
	endtask: pulse
	task cap(input logic v, input int w);
		cap_pin <= v;
		repeat (w) @(posedge clk);
	endtask: cap
	task ext(input logic v, input int w);
		ext_pin <= v;
		repeat (w) @(posedge clk);
	endtask: ext
endmodule: pin_model

//--- tb/reduced_16bit_timer_capture_bench.sv
`timescale 1ns/1ns
`include "timer_cfg.svh"
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module reduced_16bit_timer_capture_bench;
	import timer_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic en = 1'h1;
	addr_t awaddr = '0;
	addr_t araddr = '0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic cap_pin, ext_pin, tick, at_bot, at_max, at_top, irq_o, irq_c;
	int fail_count = 0;
	int checks_done = 0;
	always #20 clk = ~clk;
	timer16_core dut (.REF_CLK(clk), .RESET(rst), .CLK_EN(en),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CAPTURE_INPUT_PIN(cap_pin), .EXT_COUNT_CLOCK_PIN(ext_pin),
		.TIMER_TICK(tick), .COUNT_AT_BOTTOM(at_bot), .COUNT_AT_MAX(at_max),
		.COUNT_AT_TOP(at_top), .IRQ_OVERFLOW(irq_o), .IRQ_CAPTURE(irq_c));
	pin_model pm (.clk(clk), .cap_pin(cap_pin), .ext_pin(ext_pin));
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask: end_sim
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
		end
	endtask: chk
	task tmo(input int n);
		if (n >= 50) begin
			fail_count++;
			end_sim();
		end
	endtask: tmo
	task wr(input addr_t a, input byte_t d);
		int n;
		logic ta, tw, tb;
		logic [1:0] r;
		n = 0;
		tb = 1'h0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (tb !== 1'h1 && n < 50) begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			n++;
		end
		bready <= 1'h0;
		@(posedge clk);
		tmo(n);
		chk(r, (a > `OFF_POWER) ? `RESP_SLVERR : `RESP_OKAY);
	endtask: wr
	task rd(input addr_t a, output byte_t d);
		int n;
		logic ta, tb;
		logic [1:0] r;
		logic [31:0] v;
		n = 0;
		tb = 1'h0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (tb !== 1'h1 && n < 50) begin
			@(negedge clk);
			ta = arvalid & arready;
			tb = rvalid;
			v = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'h0;
			n++;
		end
		rready <= 1'h0;
		@(posedge clk);
		tmo(n);
		chk(r, (a > `OFF_POWER) ? `RESP_SLVERR : `RESP_OKAY);
		chk(v[31:8], 24'h000000);
		d = v[7:0];
	endtask: rd
	task w16(input addr_t a, input logic [15:0] v);
		wr(a + 6'h04, v[15:8]);
		wr(a, v[7:0]);
	endtask: w16
	task r16(input addr_t a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 6'h04, v[15:8]);
	endtask: r16
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask: wt
	function automatic logic [15:0] top_of(input int i, input logic [15:0] c);
		case (i)
			0: return `CNT_MAX;
			1: return `TOP_8;
			2: return `TOP_9;
			3: return `TOP_10;
			default: return c;
		endcase
	endfunction: top_of
	initial begin
		logic [15:0] v, c, t, g;
		byte_t b;
		int n;
		void'($urandom(72));
		wt(10);
		rst <= 1'h0;
		wt(1);
		rd(`OFF_POWER, b);
		chk(b[0], 1'h1);
		r16(`OFF_CNT_LO, g);
		chk(g, `CNT_BOTTOM);
		chk(at_bot, 1'h1);
		rd(6'h24, b);
		chk(b, 8'h00);
		wr(6'h24, 8'h5A);
		b = $urandom;
		wr(`OFF_CTRL_A, b);
		rd(`OFF_CTRL_A, g[7:0]);
		chk(g[7:0], b);
		wstrb <= 4'h0;
		wr(`OFF_CTRL_A, ~b);
		wstrb <= 4'hF;
		rd(`OFF_CTRL_A, g[7:0]);
		chk(g[7:0], b);
		v = $urandom;
		w16(`OFF_CNT_LO, v);
		r16(`OFF_CNT_LO, g);
		chk(g, v);
		wr(`OFF_CTRL_B, 8'h10);
		wr(`OFF_CNT_HI, v[15:8]);
		wr(`OFF_CNT_LO, ~v[7:0]);
		wr(`OFF_CAP_LO, v[7:0]);
		r16(`OFF_CAP_LO, g);
		chk(g, v);
		wr(`OFF_POWER, 8'h00);
		wr(`OFF_CTRL_B, {5'h00, `CS_STOP});
		wt(20);
		r16(`OFF_CNT_LO, g);
		chk(g, {v[15:8], ~v[7:0]});
		for (int i = 0; i < 5; i++) begin
			c = 16'h0100 + 16'($urandom % 32'h7F00);
			t = top_of(i, c);
			wr(`OFF_CTRL_A, byte_t'(i % 4));
			wr(`OFF_CTRL_B, (i == 4) ? 8'h17 : 8'h07);
			w16(`OFF_CAP_LO, c);
			w16(`OFF_CNT_LO, t - 16'h0001);
			wr(`OFF_FLAG, 8'h03);
			pm.pulse(1);
			wt(6);
			chk(at_top, 1'h1);
			chk(at_max, t == `CNT_MAX);
			pm.pulse(1);
			wt(6);
			r16(`OFF_CNT_LO, g);
			chk(g, `CNT_BOTTOM);
			chk(at_bot, 1'h1);
			rd(`OFF_FLAG, b);
			chk(b[`OVF_BIT], 1'h1);
		end
		wr(`OFF_MASK, 8'h00);
		chk(irq_o, 1'h0);
		wr(`OFF_MASK, 8'h01);
		chk(irq_o, 1'h1);
		wr(`OFF_FLAG, 8'h01);
		chk(irq_o, 1'h0);
		wr(`OFF_CTRL_A, 8'h00);
		for (int j = 0; j < 2; j++) begin
			wr(`OFF_CTRL_B, {5'h00, j ? `CS_EXT_FALL : `CS_EXT_RISE});
			v = 16'($urandom % 32'h7FFF);
			w16(`OFF_CNT_LO, v);
			n = 1 + $urandom % 5;
			pm.pulse(n);
			pm.ext(1'h1, 6);
			r16(`OFF_CNT_LO, g);
			chk(g, v + 16'(n + (j == 0)));
			pm.ext(1'h0, 6);
		end
		wr(`OFF_CTRL_B, 8'h47);
		wr(`OFF_MASK, 8'h02);
		v = $urandom;
		w16(`OFF_CNT_LO, v);
		wr(`OFF_FLAG, 8'h03);
		pm.cap(1'h1, 8);
		r16(`OFF_CAP_LO, g);
		chk(g, v);
		rd(`OFF_FLAG, b);
		chk(b[`CAP_BIT], 1'h1);
		chk(irq_c, 1'h1);
		pm.cap(1'h0, 8);
		wr(`OFF_CTRL_B, 8'hC7);
		c = $urandom;
		w16(`OFF_CNT_LO, c);
		wr(`OFF_FLAG, 8'h03);
		pm.cap(1'h1, 1);
		pm.cap(1'h0, 10);
		rd(`OFF_FLAG, b);
		chk(b[`CAP_BIT], 1'h0);
		pm.cap(1'h1, 10);
		r16(`OFF_CAP_LO, g);
		chk(g, c);
		wr(`OFF_CTRL_B, {5'h00, `CS_DIV1});
		w16(`OFF_CNT_LO, 16'h1000);
		chk(tick, 1'h1);
		en <= 1'h0;
		wt(200);
		en <= 1'h1;
		wr(`OFF_POWER, 8'h01);
		r16(`OFF_CNT_LO, g);
		chk(g > 16'h1000 && g < 16'h1020, 1'h1);
		chk(tick, 1'h0);
		wr(`OFF_CTRL_B, {5'h00, `CS_DIV8});
		w16(`OFF_CNT_LO, `CNT_BOTTOM);
		wr(`OFF_POWER, 8'h00);
		wt(160);
		wr(`OFF_POWER, 8'h01);
		r16(`OFF_CNT_LO, g);
		chk(g >= 16'h0010 && g <= 16'h0018, 1'h1);
		end_sim();
	end
endmodule: reduced_16bit_timer_capture_bench
